// ### include/wwd_defines.svh
// Timing constants for the windowed watchdog reset supervisor.
`ifndef WWD_DEFINES_SVH
`define WWD_DEFINES_SVH
`define WWD_CLK_MHZ            125
`define WWD_RST_SHORT_US       500
`define WWD_RST_LONG_MS        200
`define WWD_RST_SHORT_CYC      (`WWD_RST_SHORT_US * `WWD_CLK_MHZ)
`define WWD_RST_LONG_CYC       (`WWD_RST_LONG_MS * 1000 * `WWD_CLK_MHZ)
`define WWD_INT_EXPIRY         8193
`define WWD_INT_LOWER_DIV      32
`define WWD_EXT_EXPIRY         129
`define WWD_EXT_LOWER          5
`define WWD_STRAP_LOWER_MS     50
`define WWD_STRAP_UPPER_MS     1600
`define WWD_STRAP_LOWER_CYC    (`WWD_STRAP_LOWER_MS * 1000 * `WWD_CLK_MHZ)
`define WWD_STRAP_UPPER_CYC    (`WWD_STRAP_UPPER_MS * 1000 * `WWD_CLK_MHZ)
`define WWD_GLITCH_CYC         16
`endif

// ### include/wwd_pkg.sv
// Types shared by the windowed watchdog reset supervisor.
package wwd_pkg;
  typedef enum logic [1:0] {
    WWD_SRC_OPEN  = 2'b00,
    WWD_SRC_CAP   = 2'b01,
    WWD_SRC_STRAP = 2'b10
  } wwd_src_t;
  typedef enum logic [1:0] {
    WWD_ST_LOCKOUT = 2'b00,
    WWD_ST_HOLD    = 2'b01,
    WWD_ST_RUN     = 2'b10
  } wwd_state_t;
endpackage

// ### rtl/wwd_edge_det.sv
// Synchronises the kick input and flags each falling edge for one cycle.
`timescale 1ns/10ps
module wwd_edge_det (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic kick_in,
  output logic      fall_out
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      meta_r   <= 1'b1;
      sync_r   <= 1'b1;
      prev_r   <= 1'b1;
      fall_out <= 1'b0;
    end
    else
    begin
      meta_r   <= kick_in;
      sync_r   <= meta_r;
      prev_r   <= sync_r;
      fall_out <= prev_r & ~sync_r;
    end
  end
endmodule

// ### rtl/wwd_supervisor.sv
// Reset supervisor with windowed watchdog and open-drain reset output.
`timescale 1ns/10ps
`include "wwd_defines.svh"
module wwd_supervisor #(
  parameter int RST_SHORT_CYC = `WWD_RST_SHORT_CYC,
  parameter int RST_LONG_CYC  = `WWD_RST_LONG_CYC,
  parameter int STRAP_LOW_CYC = `WWD_STRAP_LOWER_CYC,
  parameter int STRAP_UP_CYC  = `WWD_STRAP_UPPER_CYC,
  parameter int GLITCH_CYC    = `WWD_GLITCH_CYC
) (
  input  wire logic                 clock_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 reset_sense_ok_in,
  input  wire logic                 out_over_in,
  input  wire logic                 out_under_in,
  input  wire logic                 in_uvlo_in,
  input  wire logic                 watchdog_kick_input_in,
  input  wire wwd_pkg::wwd_src_t    reset_timing_sel_in,
  input  wire logic                 reset_timing_tick_in,
  input  wire wwd_pkg::wwd_src_t    watchdog_timing_sel_in,
  input  wire logic                 watchdog_clk_tick_in,
  output logic                      reset_n_out,
  output logic                      reset_n_oe_out,
  output logic                      output_fault_out,
  output logic                      watchdog_expired_out
);
  localparam int TW = 32;
  wwd_pkg::wwd_state_t state_r;
  wwd_pkg::wwd_state_t state_nxt;
  logic [TW-1:0] hold_cnt_r;
  logic [TW-1:0] hold_cnt_nxt;
  logic [TW-1:0] wd_cnt_r;
  logic [TW-1:0] wd_cnt_nxt;
  logic          sense_f;
  logic          over_f;
  logic          under_f;
  logic          uvlo_f;
  logic          kick_fall;
  logic          tick_meta_r;
  logic          tick_sync_r;
  logic          tick_prev_r;
  logic          rtick_meta_r;
  logic          rtick_sync_r;
  logic          rtick_prev_r;

  // Filters are long enough to swallow transients yet short against the hold time.
  wwd_sync_filt #(.FILT_CYC(GLITCH_CYC)) u_sense (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .async_in(reset_sense_ok_in),
    .reset_val_in(1'b0), .level_out(sense_f));
  wwd_sync_filt #(.FILT_CYC(GLITCH_CYC)) u_over (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .async_in(out_over_in),
    .reset_val_in(1'b0), .level_out(over_f));
  wwd_sync_filt #(.FILT_CYC(GLITCH_CYC)) u_under (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .async_in(out_under_in),
    .reset_val_in(1'b0), .level_out(under_f));
  wwd_sync_filt #(.FILT_CYC(GLITCH_CYC)) u_uvlo (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .async_in(in_uvlo_in),
    .reset_val_in(1'b0), .level_out(uvlo_f));

  wwd_edge_det u_kick (
    .clock_in(clock_in), .rst_n_in(rst_n_in),
    .kick_in(watchdog_kick_input_in), .fall_out(kick_fall));

  // Tick pins from the timing capacitor oscillators are foreign, so each is synchronised.
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      tick_meta_r  <= 1'b0;
      tick_sync_r  <= 1'b0;
      tick_prev_r  <= 1'b0;
      rtick_meta_r <= 1'b0;
      rtick_sync_r <= 1'b0;
      rtick_prev_r <= 1'b0;
    end
    else
    begin
      tick_meta_r  <= watchdog_clk_tick_in;
      tick_sync_r  <= tick_meta_r;
      tick_prev_r  <= tick_sync_r;
      rtick_meta_r <= reset_timing_tick_in;
      rtick_sync_r <= rtick_meta_r;
      rtick_prev_r <= rtick_sync_r;
    end
  end

  wire wd_cap    = watchdog_timing_sel_in == wwd_pkg::WWD_SRC_CAP;
  wire wd_strap  = watchdog_timing_sel_in == wwd_pkg::WWD_SRC_STRAP;
  wire wd_step   = (wd_cap | wd_strap) ? (tick_sync_r & ~tick_prev_r) : 1'b1;
  wire rst_cap   = reset_timing_sel_in == wwd_pkg::WWD_SRC_CAP;
  wire rst_step  = rst_cap ? (rtick_sync_r & ~rtick_prev_r) : 1'b1;

  // In internal mode one watchdog clock is one system clock; capacitor and strap modes step on watchdog tick edges.
  wire [TW-1:0] expiry_len = wd_cap ? TW'(`WWD_EXT_EXPIRY) :
                             wd_strap ? TW'(STRAP_UP_CYC + 1) :
                             TW'(`WWD_INT_EXPIRY);
  wire [TW-1:0] upper_bnd  = expiry_len - 1'b1;
  wire [TW-1:0] lower_bnd  = wd_cap ? TW'(`WWD_EXT_LOWER) :
                             wd_strap ? TW'(STRAP_LOW_CYC) :
                             TW'(`WWD_INT_EXPIRY / `WWD_INT_LOWER_DIV);
  // Capacitor hold counts ticks; the count of ticks per hold is a design parameter.
  wire [TW-1:0] hold_len   = rst_cap ? TW'(RST_SHORT_CYC) :
                             (reset_timing_sel_in == wwd_pkg::WWD_SRC_STRAP) ?
                             TW'(RST_LONG_CYC) : TW'(RST_SHORT_CYC);

  wire out_fault  = over_f | under_f;
  wire src_fault  = ~sense_f | out_fault;
  wire wd_early   = kick_fall & (wd_cnt_r < lower_bnd);
  wire wd_late    = wd_step & (wd_cnt_r >= upper_bnd) & ~kick_fall;
  wire wd_trip    = sense_f & (wd_early | wd_late);

  always_comb
  begin
    state_nxt    = state_r;
    hold_cnt_nxt = hold_cnt_r;
    wd_cnt_nxt   = '0;
    case (state_r)
      wwd_pkg::WWD_ST_LOCKOUT:
      begin
        hold_cnt_nxt = '0;
        if (!uvlo_f)
          state_nxt = wwd_pkg::WWD_ST_HOLD;
      end
      wwd_pkg::WWD_ST_HOLD:
      begin
        if (src_fault)
          hold_cnt_nxt = '0;
        else if (hold_cnt_r + 1'b1 >= hold_len && rst_step)
        begin
          hold_cnt_nxt = '0;
          state_nxt    = wwd_pkg::WWD_ST_RUN;
        end
        else if (rst_step)
          hold_cnt_nxt = hold_cnt_r + 1'b1;
      end
      wwd_pkg::WWD_ST_RUN:
      begin
        if (src_fault || wd_trip)
          state_nxt = wwd_pkg::WWD_ST_HOLD;
        else if (!sense_f || kick_fall)
          wd_cnt_nxt = '0;
        else if (wd_step)
          wd_cnt_nxt = wd_cnt_r + 1'b1;
        else
          wd_cnt_nxt = wd_cnt_r;
      end
      default:
        state_nxt = wwd_pkg::WWD_ST_LOCKOUT;
    endcase
    if (uvlo_f)
      state_nxt = wwd_pkg::WWD_ST_LOCKOUT;
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      state_r              <= wwd_pkg::WWD_ST_LOCKOUT;
      hold_cnt_r           <= '0;
      wd_cnt_r             <= '0;
      reset_n_out          <= 1'b0;
      reset_n_oe_out       <= 1'b1;
      output_fault_out     <= 1'b0;
      watchdog_expired_out <= 1'b0;
    end
    else
    begin
      state_r              <= state_nxt;
      hold_cnt_r           <= hold_cnt_nxt;
      wd_cnt_r             <= wd_cnt_nxt;
      reset_n_out          <= 1'b0;
      reset_n_oe_out       <= state_nxt != wwd_pkg::WWD_ST_RUN;
      output_fault_out     <= ~uvlo_f & out_fault;
      watchdog_expired_out <= (state_r == wwd_pkg::WWD_ST_RUN) & wd_trip & ~uvlo_f;
    end
  end
endmodule

// ### rtl/wwd_sync_filt.sv
// Two-flop synchroniser followed by a glitch filter for one level input.
`timescale 1ns/10ps
module wwd_sync_filt #(
  parameter int FILT_CYC = 16
) (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic async_in,
  input  wire logic reset_val_in,
  output logic      level_out
);
  logic                         meta_r;
  logic                         sync_r;
  logic [$clog2(FILT_CYC+1)-1:0] cnt_r;
  wire                          differs = sync_r != level_out;
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      meta_r    <= 1'b0;
      sync_r    <= 1'b0;
      cnt_r     <= '0;
      level_out <= reset_val_in;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      if (!differs)
        cnt_r <= '0;
      else if (cnt_r == ($clog2(FILT_CYC+1))'(FILT_CYC - 1))
      begin
        cnt_r     <= '0;
        level_out <= sync_r;
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

// ### sim/wwd_host_model.sv
// Host model that toggles the watchdog kick line at a set spacing.
`timescale 1ns/10ps
module wwd_host_model (
  input  wire logic        clock_in,
  input  wire logic [15:0] gap_in,
  output logic             kick_out
);
  logic [15:0] cnt_r = 16'h0000;
  wire         flip = (gap_in != 16'h0000) && (cnt_r + 16'h0001 >= gap_in);
  initial kick_out = 1'b1;
  // A zero gap holds the line still, so the block sees no kicks.
  always @(posedge clock_in)
  begin
    // The count idles at zero so a new gap starts a full spacing from now.
    cnt_r <= #1 (flip || gap_in == 16'h0000) ? 16'h0000 : cnt_r + 16'h0001;
    if (flip)
      kick_out <= #1 ~kick_out;
  end
endmodule

// ### sim/wwd_sup_props.sv
// Port-level assertions for the watchdog reset supervisor.
`timescale 1ns/10ps
module wwd_sup_props #(
  parameter int RST_SHORT_CYC = 62500,
  parameter int GLITCH_CYC    = 16
) (
  input wire logic              clock_in,
  input wire logic              rst_n_in,
  input wire logic              reset_sense_ok_in,
  input wire logic              out_over_in,
  input wire logic              out_under_in,
  input wire logic              in_uvlo_in,
  input wire logic              watchdog_kick_input_in,
  input wire wwd_pkg::wwd_src_t reset_timing_sel_in,
  input wire logic              reset_timing_tick_in,
  input wire wwd_pkg::wwd_src_t watchdog_timing_sel_in,
  input wire logic              watchdog_clk_tick_in,
  input wire logic              reset_n_out,
  input wire logic              reset_n_oe_out,
  input wire logic              output_fault_out,
  input wire logic              watchdog_expired_out
);
  int   bad_c = 0;
  int   uv_c = 0;
  int   ok_c = 0;
  int   hi_c = 0;
  int   idle_c = 0;
  logic kick_q = 1'b1;
  wire  bad = in_uvlo_in | ~reset_sense_ok_in | out_over_in | out_under_in;
  wire  fall = kick_q & ~watchdog_kick_input_in;
  // Margins cover the two sync flops plus the glitch filter latency.
  always_ff @(posedge clock_in)
  begin
    bad_c  <= bad ? bad_c + 1 : 0;
    uv_c   <= in_uvlo_in ? uv_c + 1 : 0;
    ok_c   <= (out_over_in | out_under_in) ? 0 : ok_c + 1;
    hi_c   <= reset_n_oe_out ? hi_c + 1 : 0;
    idle_c <= (!reset_n_oe_out && !fall) ? idle_c + 1 : 0;
    kick_q <= watchdog_kick_input_in;
  end
  sequence trip_s;
    watchdog_expired_out ##1 !watchdog_expired_out;
  endsequence
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  a_pin_never_high: assert property (reset_n_out == 1'b0)
    else $error("reset pin driven high");
  a_bad_src_resets: assert property (bad_c > GLITCH_CYC + 6 |-> reset_n_oe_out)
    else $error("reset not asserted for bad source");
  a_lockout_no_fault: assert property (uv_c > GLITCH_CYC + 6 |-> !output_fault_out)
    else $error("fault flagged in lockout");
  a_fault_clears: assert property (ok_c > GLITCH_CYC + 6 |-> !output_fault_out)
    else $error("fault stuck after recovery");
  a_hold_full_len: assert property ($fell(reset_n_oe_out)
    && reset_timing_sel_in == wwd_pkg::WWD_SRC_OPEN |-> hi_c >= RST_SHORT_CYC)
    else $error("reset released early");
  a_trip_one_pulse: assert property (watchdog_expired_out |-> trip_s)
    else $error("trip pulse too long");
  a_trip_resets: assert property (watchdog_expired_out |-> ##[0:2] reset_n_oe_out)
    else $error("trip without reset");
  a_trip_from_run: assert property (watchdog_expired_out |-> $past(!reset_n_oe_out))
    else $error("trip during hold");
  a_late_bound: assert property (watchdog_timing_sel_in == wwd_pkg::WWD_SRC_OPEN
    |-> idle_c < 8200)
    else $error("late trip missing");
endmodule
bind wwd_supervisor wwd_sup_props #(.RST_SHORT_CYC(RST_SHORT_CYC), .GLITCH_CYC(GLITCH_CYC))
  wwd_sup_props_i (.*);

// ### sim/wwd_supervisor_bench.sv
// Self-checking bench for the watchdog reset supervisor.
`timescale 1ns/10ps
module wwd_supervisor_bench;
  localparam int HOLD = 40;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              sense = 1'b0;
  logic              over = 1'b0;
  logic              under = 1'b0;
  logic              uvlo = 1'b1;
  logic              tick = 1'b0;
  logic [15:0]       gap = 16'h0000;
  wwd_pkg::wwd_src_t wsel = wwd_pkg::WWD_SRC_OPEN;
  wwd_pkg::wwd_src_t rsel = wwd_pkg::WWD_SRC_OPEN;
  logic              kick;
  logic              pin;
  logic              oe;
  logic              fault;
  logic              expd;
  int                err_count = 0;
  int                checks_done = 0;
  int                cycles = 0;
  int                trips = 0;
  int                n;
  int                t0;
  wwd_supervisor #(.RST_SHORT_CYC(HOLD), .RST_LONG_CYC(400), .STRAP_LOW_CYC(20),
    .STRAP_UP_CYC(200), .GLITCH_CYC(2)) wwd_supervisor_i (.clock_in(clk), .rst_n_in(rst_n),
    .reset_sense_ok_in(sense), .out_over_in(over), .out_under_in(under), .in_uvlo_in(uvlo),
    .watchdog_kick_input_in(kick), .reset_timing_sel_in(rsel),
    .reset_timing_tick_in(tick), .watchdog_timing_sel_in(wsel), .watchdog_clk_tick_in(tick),
    .reset_n_out(pin), .reset_n_oe_out(oe), .output_fault_out(fault),
    .watchdog_expired_out(expd));
  wwd_host_model wwd_host_model_i (.clock_in(clk), .gap_in(gap), .kick_out(kick));
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    tick <= #1 ~tick;
    if (expd === 1'b1)
      trips <= trips + 1;
    if (cycles == 30000)
    begin
      err_count++;
      final_report();
    end
  end
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %b want %b", $time, got, exp);
    end
  endtask
  task chk_rng(input int v, input int lo, input int hi);
    checks_done++;
    if (v < lo || v > hi)
    begin
      err_count++;
      $display("ERROR %0t count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask
  task wait_oe(input logic v, output int k);
    k = 0;
    while (oe !== v && k < 20000)
    begin
      cyc(1);
      k++;
    end
  endtask
  task t_lockout;
    sense = 1'b1;
    over = 1'b1;
    cyc(30);
    chk(oe, 1'b1);
    chk(fault, 1'b0);
    uvlo = 1'b0;
    cyc(30);
    chk(fault, 1'b1);
    over = 1'b0;
    under = 1'b1;
    cyc(30);
    chk(oe, 1'b1);
    under = 1'b0;
    wait_oe(1'b0, n);
    chk_rng(n, HOLD, HOLD + 20);
    chk(fault, 1'b0);
  endtask
  task t_glitch_sense;
    over = 1'b1;
    sense = 1'b0;
    cyc(1);
    over = 1'b0;
    sense = 1'b1;
    cyc(20);
    chk(oe, 1'b0);
    sense = 1'b0;
    cyc(20);
    chk(oe, 1'b1);
    sense = 1'b1;
    wait_oe(1'b0, n);
    chk_rng(n, HOLD, HOLD + 20);
  endtask
  task t_kicks;
    t0 = trips;
    gap = 16'h012c;
    cyc(3000);
    chk(oe, 1'b0);
    chk_rng(trips - t0, 0, 0);
  endtask
  task t_early_late;
    gap = 16'h003c;
    wait_oe(1'b1, n);
    gap = 16'h0000;
    chk_rng(n, 1, 1000);
    wait_oe(1'b0, n);
    chk_rng(n, HOLD - 1, HOLD + 3);
    wait_oe(1'b1, n);
    chk_rng(n, 8190, 8198);
    wsel = wwd_pkg::WWD_SRC_CAP;
    wait_oe(1'b0, n);
    wait_oe(1'b1, n);
    chk_rng(n, 250, 262);
    wsel = wwd_pkg::WWD_SRC_STRAP;
    rsel = wwd_pkg::WWD_SRC_STRAP;
    wait_oe(1'b0, n);
    chk_rng(n, 396, 404);
    wait_oe(1'b1, n);
    chk_rng(n, 395, 410);
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    rst_n = 1'b1;
    t_lockout();
    t_glitch_sense();
    t_kicks();
    t_early_late();
    final_report();
  end
endmodule
